// ==== common/hpba_pkg.sv ====
package hpba_pkg;
    // ==========================================================
    // Bus widths
    localparam int ADDR_HI       = 31;
    localparam int ADDR_LO       = 3;
    localparam int ADDR_W        = ADDR_HI - ADDR_LO + 1;
    localparam int DATA_W        = 64;
    localparam int REQ_W         = 5;
    localparam int RESP_W        = 3;
    // ==========================================================
    // Response codes (true sense; inverted on the wire)
    localparam logic [2:0] RESP_IDLE     = 3'h0;
    localparam logic [2:0] RESP_RETRY    = 3'h1;
    localparam logic [2:0] RESP_DEFER    = 3'h2;
    localparam logic [2:0] RESP_RSVD     = 3'h3;
    localparam logic [2:0] RESP_HARDFAIL = 3'h4;
    localparam logic [2:0] RESP_NODATA   = 3'h5;
    localparam logic [2:0] RESP_IWB      = 3'h6;
    localparam logic [2:0] RESP_NORMAL   = 3'h7;
    // ==========================================================
    // Request command encodings used by the sampler
    localparam logic [4:0] REQ_SPECIAL   = 5'h08;
    localparam logic [7:0] SPECIAL_SHUTDOWN = 8'h00;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS     = 10;
    localparam int PROC_RESET_NS     = 1000;
    localparam int PROC_RESET_CYC    = (PROC_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_PULSE_NS     = 160;
    localparam int INIT_PULSE_CYC    = (INIT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W             = 8;
    localparam int FIFO_DEPTH        = 8;
    localparam logic [7:0] ONE8      = 8'h01;
endpackage : hpba_pkg

// ==== hw/hpba_fifo.sv ====
`timescale 1ns/1ps
module hpba_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } hpba_fifo_state_t;
    hpba_fifo_state_t st, next_st;
    logic push, pop;
    assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign out_data  = st.mem[st.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = in_data;
            next_st.wp = (st.wp == AW'(DEPTH-1)) ? '0 : st.wp + AW'(1);
        end
        if (pop) begin
            next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : st.rp + AW'(1);
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end
    fifo_bound_a: assert property (@(posedge clk) disable iff (reset)
        st.cnt <= (AW+1)'(DEPTH)) else $error("fifo count over depth");
endmodule : hpba_fifo

// ==== hw/hpba_agent.sv ====
`timescale 1ns/1ps
// Function
// - Address and data inverted on wire
// - Hash suffix means asserted low
// - Owner strobes address in first clock
// - Block-next-request throttles new requests
// - Data busy held across multi-clock transfers; here asserted only in a data clock while more words wait in the write buffer
// - Data ready asserted each transfer clock
// - Caching agents report hit and dirty hit
// - Hit plus dirty hit extends snoop
// - Command valid in both request clocks
// - Three response lines encode response type
module hpba_agent
    import hpba_pkg::*;
#(
    parameter int PROC_RESET_CYCLES = PROC_RESET_CYC,
    parameter int FIFO_D            = FIFO_DEPTH
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              ce,
    // System side
    input  wire logic              system_reset_in_n,
    input  wire logic              soft_reset_req,
    output logic                   proc_reset_n,
    output logic                   proc_init_n,
    // Snoop request from PCI / graphics side
    input  wire logic              snoop_req,
    input  wire logic [ADDR_W-1:0] snoop_addr,
    input  wire logic [REQ_W-1:0]  snoop_cmd_a,
    input  wire logic [REQ_W-1:0]  snoop_cmd_b,
    output logic                   snoop_ack,
    output logic                   snoop_blocked,
    output logic                   snoop_hit,
    output logic                   snoop_dirty,
    // Response / data plumbing for processor cycles
    input  wire logic              resp_valid,
    input  wire logic [RESP_W-1:0] resp_code,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              wr_valid,
    output logic                   wr_ready,
    output logic                   pipe_full,
    // Bus pins
    input  wire logic [ADDR_W-1:0] addr_in_n,
    output logic      [ADDR_W-1:0] addr_out_n,
    output logic                   addr_oe,
    input  wire logic              addr_strobe_in_n,
    output logic                   addr_strobe_out_n,
    output logic                   addr_strobe_oe,
    input  wire logic [REQ_W-1:0]  request_cmd_in_n,
    output logic      [REQ_W-1:0]  request_cmd_out_n,
    output logic                   request_cmd_oe,
    output logic                   priority_bus_req_n,
    input  wire logic              host_lock_n,
    output logic                   block_next_req_n,
    input  wire logic              snoop_hit_in_n,
    input  wire logic              snoop_hit_dirty_n,
    output logic                   target_ready_n,
    output logic                   data_bus_busy_n,
    output logic                   data_ready_n,
    output logic      [DATA_W-1:0] host_data_out_n,
    output logic                   host_data_oe,
    output logic                   defer_n,
    output logic      [RESP_W-1:0] response_code_n
);
    // ==========================================================
    // State
    typedef enum logic [2:0] {S_IDLE, S_REQ_A, S_REQ_B, S_SNOOP, S_DONE} hpba_snp_t;
    typedef struct packed {
        hpba_snp_t           snp;
        logic [ADDR_W-1:0]   addr_n;
        logic                addr_oe;
        logic                ads_n;
        logic                ads_oe;
        logic [REQ_W-1:0]    cmd_n;
        logic                cmd_oe;
        logic                priority_bus_req_n_n;
        logic                bnr_n;
        logic                ack;
        logic                blocked;
        logic                hit;
        logic                dirty;
        logic                req2;          // second clock of observed request
        logic                shut_seen;
        logic [CNT_W-1:0]    rst_cnt;
        logic                prst_n;
        logic [CNT_W-1:0]    init_cnt;
        logic                init_n;
        logic                trdy_n;
        logic                data_bus_busy_n_n;
        logic                data_ready_n_n;
        logic [DATA_W-1:0]   data_n;
        logic                data_oe;
        logic                defer_n;
        logic [RESP_W-1:0]   rs_n;
        logic [CNT_W-1:0]    fill;          // words held in the write buffer
    } hpba_state_t;
    hpba_state_t st, next_st;
    localparam hpba_state_t RESET_ST = '{snp: S_IDLE, addr_n: '1, addr_oe: 1'b0, ads_n: 1'b1, ads_oe: 1'b0,
        cmd_n: '1, cmd_oe: 1'b0, priority_bus_req_n_n: 1'b1, bnr_n: 1'b1, ack: 1'b0, blocked: 1'b0, hit: 1'b0,
        dirty: 1'b0, req2: 1'b0, shut_seen: 1'b0, rst_cnt: '0, prst_n: 1'b0, init_cnt: '0,
        init_n: 1'b1, trdy_n: 1'b1, data_bus_busy_n_n: 1'b1, data_ready_n_n: 1'b1, data_n: '1, data_oe: 1'b0,
        defer_n: 1'b1, rs_n: '1, fill: '0};

    logic [DATA_W-1:0] fifo_data;
    logic              fifo_valid;
    logic              fifo_pop;
    logic              locked;
    logic              new_req;

    // Write data waits here until the bus can take it; back-pressure reaches wr_ready
    hpba_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_D)) hpba_fifo_i (
        .clk       (clk),
        .reset     (reset),
        .ce        (ce),
        .in_data   (wr_data),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    assign locked   = !host_lock_n;
    assign new_req  = !addr_strobe_in_n && st.snp == S_IDLE;
    // Data leaves the buffer only while a response phase is paired with it
    assign fifo_pop = fifo_valid && resp_valid && st.snp == S_IDLE;

    // ==========================================================
    // Next state
    always_comb begin
        next_st         = st;
        next_st.ack     = 1'b0;
        next_st.ads_n   = 1'b1;
        next_st.ads_oe  = 1'b0;
        next_st.data_ready_n_n  = 1'b1;
        next_st.data_bus_busy_n_n  = 1'b1;
        next_st.data_oe = 1'b0;
        next_st.trdy_n  = 1'b1;
        next_st.defer_n = 1'b1;
        next_st.rs_n    = ~RESP_IDLE;
        next_st.blocked = locked && snoop_req;
        // Processor reset held for a fixed time after system reset negates
        if (!system_reset_in_n) begin
            next_st.rst_cnt = '0;
            next_st.prst_n  = 1'b0;
        end else if (st.rst_cnt != CNT_W'(PROC_RESET_CYCLES)) begin
            next_st.rst_cnt = st.rst_cnt + ONE8;
        end else begin
            next_st.prst_n  = 1'b1;
        end
        // Init pulse
        if (st.init_cnt != '0) begin
            next_st.init_cnt = st.init_cnt - ONE8;
            next_st.init_n   = (st.init_cnt == ONE8);
        end else if (st.shut_seen || soft_reset_req) begin
            next_st.init_cnt  = CNT_W'(INIT_PULSE_CYC);
            next_st.init_n    = 1'b0;
            next_st.shut_seen = 1'b0;
        end
        // Second request clock: a new shutdown wins over the clear above
        next_st.req2 = !addr_strobe_in_n;
        if (st.req2 && st.snp == S_IDLE && ~request_cmd_in_n == REQ_SPECIAL
            && ~addr_in_n[7:0] == SPECIAL_SHUTDOWN) begin
            next_st.shut_seen = 1'b1;
        end
        // Pipeline throttle while the write buffer is full
        next_st.bnr_n = wr_ready;
        next_st.fill  = st.fill + CNT_W'(wr_valid && wr_ready) - CNT_W'(fifo_pop);
        // Responses to processor cycles
        if (resp_valid && st.snp == S_IDLE) begin
            next_st.rs_n = ~resp_code;
            if (resp_code == RESP_DEFER || resp_code == RESP_RETRY) begin
                next_st.defer_n = 1'b0;
            end
            if (fifo_valid) begin
                next_st.trdy_n  = 1'b0;
                next_st.data_n  = ~fifo_data;
                next_st.data_oe = 1'b1;
                next_st.data_ready_n_n  = 1'b0;
                next_st.data_bus_busy_n_n  = !(st.fill > ONE8);
            end
        end
        // Snoop sequencer
        unique case (st.snp)
            S_IDLE: begin
                if (snoop_req && !locked && !new_req) begin
                    next_st.priority_bus_req_n_n = 1'b0;
                    next_st.snp    = S_REQ_A;
                end
            end
            S_REQ_A: begin
                if (locked) begin
                    next_st.priority_bus_req_n_n = 1'b1;
                    next_st.snp    = S_IDLE;
                end else if (block_next_req_n && addr_strobe_in_n) begin
                    next_st.ads_n   = 1'b0;
                    next_st.ads_oe  = 1'b1;
                    next_st.addr_n  = ~snoop_addr;
                    next_st.addr_oe = 1'b1;
                    next_st.cmd_n   = ~snoop_cmd_a;
                    next_st.cmd_oe  = 1'b1;
                    next_st.snp     = S_REQ_B;
                end
            end
            S_REQ_B: begin
                next_st.cmd_n = ~snoop_cmd_b;
                next_st.snp   = S_SNOOP;
            end
            S_SNOOP: begin
                next_st.addr_oe = 1'b0;
                next_st.cmd_oe  = 1'b0;
                next_st.priority_bus_req_n_n  = 1'b1;
                // Both lines low means stall; wait for the snoop result
                if (!(!snoop_hit_in_n && !snoop_hit_dirty_n)) begin
                    next_st.hit   = !snoop_hit_in_n;
                    next_st.dirty = !snoop_hit_dirty_n;
                    next_st.ack   = 1'b1;
                    next_st.snp   = S_DONE;
                end
            end
            S_DONE: begin
                next_st.snp = S_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Registers, all on the rising host clock
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= RESET_ST;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign proc_reset_n       = st.prst_n;
    assign proc_init_n        = st.init_n;
    assign snoop_ack          = st.ack;
    assign snoop_blocked      = st.blocked;
    assign snoop_hit          = st.hit;
    assign snoop_dirty        = st.dirty;
    assign pipe_full          = !st.bnr_n;
    assign addr_out_n         = st.addr_n;
    assign addr_oe            = st.addr_oe;
    assign addr_strobe_out_n  = st.ads_n;
    assign addr_strobe_oe     = st.ads_oe;
    assign request_cmd_out_n  = st.cmd_n;
    assign request_cmd_oe     = st.cmd_oe;
    assign priority_bus_req_n = st.priority_bus_req_n_n;
    assign block_next_req_n   = st.bnr_n;
    assign target_ready_n     = st.trdy_n;
    assign data_bus_busy_n    = st.data_bus_busy_n_n;
    assign data_ready_n       = st.data_ready_n_n;
    assign host_data_out_n    = st.data_n;
    assign host_data_oe       = st.data_oe;
    assign defer_n            = st.defer_n;
    assign response_code_n    = st.rs_n;

    // ==========================================================
    // Checks
    sequence s_strobe;
        !addr_strobe_out_n && addr_strobe_oe;
    endsequence
    sequence s_second;
        request_cmd_oe ##0 !priority_bus_req_n;
    endsequence
    strobe_owner_a: assert property (@(posedge clk) disable iff (reset)
        s_strobe |-> !priority_bus_req_n) else $error("strobe without priority request");
    cmd_two_clk_a: assert property (@(posedge clk) disable iff (reset)
        s_strobe |-> request_cmd_oe ##1 s_second) else $error("command not held two clocks");
    addr_drive_a: assert property (@(posedge clk) disable iff (reset)
        addr_oe |-> !priority_bus_req_n) else $error("address driven without ownership");
    defer_resp_a: assert property (@(posedge clk) disable iff (reset)
        !defer_n |-> (~response_code_n == RESP_DEFER || ~response_code_n == RESP_RETRY))
        else $error("defer with wrong response");
    data_ready_n_data_a: assert property (@(posedge clk) disable iff (reset)
        !data_ready_n |-> host_data_oe && !target_ready_n) else $error("data ready without data");
    reset_hold_a: assert property (@(posedge clk) disable iff (reset)
        ce && $fell(system_reset_in_n) |=> !proc_reset_n) else $error("proc reset not following");
    init_pulse_a: assert property (@(posedge clk) disable iff (reset || !ce)
        $fell(proc_init_n) |-> !proc_init_n [*8] ##1 !proc_init_n [*8] ##1 proc_init_n)
        else $error("init pulse length wrong");
    lock_block_a: assert property (@(posedge clk) disable iff (reset)
        ce && !host_lock_n && st.snp == S_IDLE |=> st.snp == S_IDLE) else $error("snoop started under lock");
    throttle_a: assert property (@(posedge clk) disable iff (reset)
        ce && !wr_ready |=> !block_next_req_n) else $error("block next request missing");
endmodule : hpba_agent

// ==== dv/hpba_proc_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// Processor on the shared bus: two-clock requests, snoop answers
module hpba_proc_model
    import hpba_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              go,
    input  wire logic [REQ_W-1:0]  cmd_a,
    input  wire logic [REQ_W-1:0]  cmd_b,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              lock,
    input  wire logic [1:0]        hit_mode,
    input  wire logic              bus_strobe_n,
    input  wire logic              priority_bus_req_n_n,
    input  wire logic              bnr_n,
    output logic      [ADDR_W-1:0] addr_n,
    output logic                   strobe_n,
    output logic      [REQ_W-1:0]  cmd_n,
    output logic                   lock_n,
    output logic                   hit_n,
    output logic                   snoop_hit_dirty_n_n
);
    logic       second;
    logic [2:0] snp;
    // Both lines low above 3 stretch the snoop window before the result
    assign hit_n  = !(snp > 3'h3 || (snp != 3'h0 && hit_mode[0]));
    assign snoop_hit_dirty_n_n = !(snp > 3'h3 || (snp != 3'h0 && hit_mode == 2'h2));
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            second   <= 1'b0;
            snp      <= 3'h0;
            addr_n   <= '1;
            strobe_n <= 1'b1;
            cmd_n    <= '1;
            lock_n   <= 1'b1;
        end else begin
            lock_n <= ~lock;
            second <= 1'b0;
            if (go && priority_bus_req_n_n && bnr_n && !second) begin
                second   <= 1'b1;
                strobe_n <= 1'b0;
                addr_n   <= ~addr;
                cmd_n    <= ~cmd_a;
            end else if (second) begin
                strobe_n <= 1'b1;
                cmd_n    <= ~cmd_b;
            end else begin
                // Released lines go back high through the pull-ups
                addr_n <= '1;
                cmd_n  <= '1;
            end
            if (snp != 3'h0)
                snp <= snp - 3'h1;
            else if (!bus_strobe_n && strobe_n)
                snp <= (hit_mode == 2'h3) ? 3'h5 : 3'h3;
        end
    end
endmodule : hpba_proc_model

// ==== dv/hpba_agent_bench.sv ====
`timescale 1ns/1ps
// ==========================================================
// Bench: agent plus one processor model on an open-drain bus
module hpba_agent_bench
    import hpba_pkg::*;
;
    // Short reset stretch keeps the run brief
    localparam int PRC   = 4;
    // Tests need about 300 cycles; fifty times that means a hang
    localparam int LIMIT = 15000;
    logic clk = 1'b0, reset = 1'b1, ce = 1'b1, system_reset_in_n = 1'b1, soft_reset_req = 1'b0;
    logic snoop_req = 1'b0, resp_valid = 1'b0, wr_valid = 1'b0, go = 1'b0, lock = 1'b0;
    logic [ADDR_W-1:0] snoop_addr = '0, m_addr = '0, addr_in_n, addr_out_n, m_addr_n;
    logic [REQ_W-1:0]  snoop_cmd_a = '0, snoop_cmd_b = '0, m_cmd_a = '0, m_cmd_b = '0;
    logic [REQ_W-1:0]  request_cmd_in_n, request_cmd_out_n, m_cmd_n;
    logic [RESP_W-1:0] resp_code = '0, response_code_n;
    logic [DATA_W-1:0] wr_data = '0, host_data_out_n;
    logic [1:0]        hit_mode = '0;
    logic proc_reset_n, proc_init_n, snoop_ack, snoop_blocked, snoop_hit, snoop_dirty, wr_ready, pipe_full;
    logic addr_oe, addr_strobe_in_n, addr_strobe_out_n, addr_strobe_oe, request_cmd_oe, priority_bus_req_n;
    logic host_lock_n, block_next_req_n, snoop_hit_in_n, snoop_hit_dirty_n, target_ready_n, data_bus_busy_n;
    logic data_ready_n, host_data_oe, defer_n, m_strobe_n;
    int   n_fail = 0, n_checks = 0, cyc = 0;

    hpba_agent #(.PROC_RESET_CYCLES(PRC), .FIFO_D(FIFO_DEPTH)) hpba_agent_i (.*);
    hpba_proc_model hpba_proc_model_i (
        .clk(clk), .reset(reset), .go(go), .cmd_a(m_cmd_a), .cmd_b(m_cmd_b), .addr(m_addr), .lock(lock),
        .hit_mode(hit_mode), .bus_strobe_n(addr_strobe_in_n), .priority_bus_req_n_n(priority_bus_req_n),
        .bnr_n(block_next_req_n), .addr_n(m_addr_n), .strobe_n(m_strobe_n), .cmd_n(m_cmd_n),
        .lock_n(host_lock_n), .hit_n(snoop_hit_in_n), .snoop_hit_dirty_n_n(snoop_hit_dirty_n));
    // Wired-AND: a line is low when any party pulls it low
    assign addr_in_n        = m_addr_n & (addr_oe ? addr_out_n : '1);
    assign addr_strobe_in_n = m_strobe_n & (addr_strobe_oe ? addr_strobe_out_n : 1'b1);
    assign request_cmd_in_n = m_cmd_n & (request_cmd_oe ? request_cmd_out_n : '1);
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_fail++;
            final_report();
        end
    end
    // ==========================================================
    // Helpers
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic settle(const ref logic s, input logic v, input int lim);
        repeat (lim) begin
            @(negedge clk);
            if (s === v) break;
        end
    endtask : settle
    task automatic stretch();
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (proc_reset_n !== 1'b1 && n < PRC + 10);
        chk("reset stretch", 1'b1, n >= PRC && n <= PRC + 3);
    endtask : stretch
    // ==========================================================
    // Scenarios
    task automatic snoop(input logic [1:0] mode, input logic [ADDR_W-1:0] a, input logic [REQ_W-1:0] ca, cb);
        @(posedge clk);
        hit_mode    <= mode;
        snoop_req   <= 1'b1;
        snoop_addr  <= a;
        snoop_cmd_a <= ca;
        snoop_cmd_b <= cb;
        settle(priority_bus_req_n, 1'b0, 6);
        chk("priority request", 1'b0, priority_bus_req_n);
        settle(addr_strobe_out_n, 1'b0, 6);
        chk("bus drive", 1'b1, addr_strobe_oe & addr_oe & request_cmd_oe);
        chk("snoop address", ADDR_W'(~a), addr_out_n);
        chk("first command", REQ_W'(~ca), request_cmd_out_n);
        @(negedge clk);
        chk("strobe one clock", 1'b1, addr_strobe_out_n);
        chk("second command", REQ_W'(~cb), request_cmd_out_n);
        settle(snoop_ack, 1'b1, 20);
        chk("snoop done", 1'b1, snoop_ack);
        chk("snoop result", {mode[0], mode == 2'h2}, {snoop_hit, snoop_dirty});
        @(posedge clk);
        snoop_req <= 1'b0;
        repeat (12) @(posedge clk);
    endtask : snoop
    task automatic locked();
        @(posedge clk);
        lock <= 1'b1;
        repeat (2) @(posedge clk);
        snoop_req <= 1'b1;
        repeat (3) @(negedge clk);
        chk("snoop refused", 1'b1, snoop_blocked);
        repeat (8) begin
            @(negedge clk);
            chk("idle under lock", 2'b01, {addr_oe, priority_bus_req_n});
        end
        @(posedge clk);
        snoop_req <= 1'b0;
        lock      <= 1'b0;
        snoop(2'h1, 29'h1555_0000, 5'h04, 5'h02);
        $display("lock test done");
    endtask : locked
    task automatic resp(input logic [2:0] code, input logic dat, input logic [63:0] d, input logic more);
        @(posedge clk);
        resp_valid <= 1'b1;
        resp_code  <= code;
        @(posedge clk);
        resp_valid <= 1'b0;
        @(negedge clk);
        chk("response code", 3'(~code), response_code_n);
        chk("defer", !(code == RESP_RETRY || code == RESP_DEFER), defer_n);
        chk("target and data ready", {!dat, !dat, dat}, {target_ready_n, data_ready_n, host_data_oe});
        chk("data busy", !(dat && more), data_bus_busy_n);
        if (dat)
            chk("host data", ~d, host_data_out_n);
        @(negedge clk);
        chk("response idle", 3'h7, response_code_n);
    endtask : resp
    task automatic push(input logic [63:0] d);
        logic ok;
        @(posedge clk);
        wr_valid <= 1'b1;
        wr_data  <= d;
        do begin
            @(negedge clk);
            ok = wr_ready;
            @(posedge clk);
        end while (ok !== 1'b1);
        wr_valid <= 1'b0;
    endtask : push
    task automatic fill_drain();
        for (int i = 0; i < FIFO_DEPTH; i++) push(64'h0f1e_2d3c_4b5a_6900 + 64'(i));
        @(posedge clk);
        wr_valid <= 1'b1;
        wr_data  <= '1;
        repeat (3) @(negedge clk);
        chk("full throttles", 3'b010, {wr_ready, pipe_full, block_next_req_n});
        @(posedge clk);
        wr_valid <= 1'b0;
        // Spaced responses stall the draining side
        for (int i = 0; i < FIFO_DEPTH; i++)
            resp(RESP_NORMAL, 1'b1, 64'h0f1e_2d3c_4b5a_6900 + 64'(i), i < FIFO_DEPTH - 1);
        chk("throttle released", 1'b1, block_next_req_n);
        $display("buffer test done");
    endtask : fill_drain
    task automatic init_pulse(input logic from_bus);
        int n;
        @(posedge clk);
        if (from_bus) begin
            go      <= 1'b1;
            m_cmd_a <= REQ_SPECIAL;
            m_cmd_b <= REQ_SPECIAL;
            m_addr  <= '0;
        end else
            soft_reset_req <= 1'b1;
        @(posedge clk);
        go             <= 1'b0;
        soft_reset_req <= 1'b0;
        settle(proc_init_n, 1'b0, 10);
        n = 0;
        while (proc_init_n === 1'b0 && n < 40) begin
            n++;
            @(negedge clk);
        end
        chk("init pulse length", INIT_PULSE_CYC, n);
        $display("init test done");
    endtask : init_pulse
    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        chk("outputs in reset", 7'h2f, {proc_reset_n, proc_init_n, addr_oe, priority_bus_req_n, response_code_n});
        @(posedge clk);
        reset <= 1'b0;
        stretch();
        for (int m = 0; m < 4; m++) snoop(2'(m), ADDR_W'(32'h0abc_d012 + m), 5'h06, 5'h0c);
        $display("snoop test done");
        locked();
        for (int c = 0; c < 8; c++) resp(3'(c), 1'b0, '0, 1'b0);
        $display("response test done");
        fill_drain();
        init_pulse(1'b1);
        init_pulse(1'b0);
        @(posedge clk);
        system_reset_in_n <= 1'b0;
        repeat (3) @(negedge clk);
        chk("processor reset follows", 1'b0, proc_reset_n);
        @(posedge clk);
        system_reset_in_n <= 1'b1;
        stretch();
        $display("system reset test done");
        final_report();
    end
endmodule : hpba_agent_bench
